// File: logic/scce_pkg.sv
// constants for the step change condition evaluator
package scce_pkg;
	// =====================================================
	// register byte offsets
	localparam logic [4:0] SCCE_OFS_PROP   = 5'h00; // step_change_property
	localparam logic [4:0] SCCE_OFS_VAL1   = 5'h04; // first_condition_value
	localparam logic [4:0] SCCE_OFS_VAL2   = 5'h08; // second_condition_value
	localparam logic [4:0] SCCE_OFS_CTRL   = 5'h0c; // restart strobe
	localparam logic [4:0] SCCE_OFS_STATUS = 5'h10; // evaluator state
	// =====================================================
	// property field layout, one nibble each
	localparam int SCCE_TYPE1_LSB = 0;
	localparam int SCCE_TYPE2_LSB = 4;
	localparam int SCCE_LOGIC_LSB = 8;
	localparam int SCCE_MODE_LSB  = 12;
	// control and status bit positions
	localparam int SCCE_CTRL_RESTART = 0;
	localparam int SCCE_ST_ARMED     = 0;
	localparam int SCCE_ST_DONE      = 1;
	localparam int SCCE_ST_MET_LSB   = 2;
	localparam int SCCE_ST_MODE_LSB  = 4;
	// reset values
	localparam logic [15:0] SCCE_PROP_RST = 16'h0000;
	localparam logic [15:0] SCCE_VAL_RST  = 16'h0000;
	// =====================================================
	// condition types, combination logic, level and edge codes
	localparam logic [3:0] SCCE_TYPE_UNCOND = 4'h0;
	localparam logic [3:0] SCCE_TYPE_DELAY  = 4'h1;
	localparam logic [3:0] SCCE_TYPE_EDGE   = 4'h2;
	localparam logic [3:0] SCCE_TYPE_LEVEL  = 4'h3;
	localparam logic [3:0] SCCE_LOGIC_NONE  = 4'h0;
	localparam logic [3:0] SCCE_LOGIC_AND   = 4'h1;
	localparam logic [3:0] SCCE_LOGIC_OR    = 4'h2;
	localparam logic [15:0] SCCE_EDGE_RISE  = 16'h0000;
	localparam logic [15:0] SCCE_EDGE_FALL  = 16'h0001;
	localparam logic [15:0] SCCE_EDGE_ANY   = 16'h0002;
	localparam logic [15:0] SCCE_LEVEL_HIGH = 16'h0003;
	localparam logic [15:0] SCCE_LEVEL_LOW  = 16'h0004;
	localparam logic [3:0] SCCE_MODE_MAX    = 4'h5;
	// =====================================================
	// timing
	localparam int SCCE_CLK_MHZ    = 200;
	localparam int SCCE_MS_IN_US   = 1000;
	localparam int SCCE_CLK_PER_MS = SCCE_CLK_MHZ * SCCE_MS_IN_US;
	// axi responses
	localparam logic [1:0] SCCE_RESP_OKAY   = 2'b00;
	localparam logic [1:0] SCCE_RESP_SLVERR = 2'b10;
endpackage : scce_pkg

// File: logic/scce_top.sv
// step change condition evaluator with axi4-lite registers
// Overview of operation
// - each condition has type code 0 to 3
// - unconditional type is met at once, value ignored
// - delay type met after value milliseconds elapse
// - edge value 0 rise, 1 fall, 2 either
// - level value 3 high, value 4 low
// - logic 0 first only, 1 and, 2 or
// - transient mode 0 to 5 selects handover style; transient_mode passes any value 0 to 15 unchecked
// - values 0 to 65535, default 0, apply on restart
//
// The register offsets and register access over AXI4-Lite were decided locally.
module scce_top
	import scce_pkg::*;
#(
	parameter int unsigned CLK_PER_MS = scce_pkg::SCCE_CLK_PER_MS
) (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite write channels
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output      logic        s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output      logic        s_axi_wready,
	output      logic [1:0]  s_axi_bresp,
	output      logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read channels
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output      logic        s_axi_arready,
	output      logic [31:0] s_axi_rdata,
	output      logic [1:0]  s_axi_rresp,
	output      logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// step input pin and motion side
	input  wire logic        position_step_input_n,
	input  wire logic        group_start,
	output      logic        handover_pulse,
	output      logic [3:0]  transient_mode,
	output      logic        armed
);
	import scce_pkg::*;

	// =====================================================
	// elaboration check
	if (CLK_PER_MS < 2) begin : g_bad_rate
		$error("CLK_PER_MS must be at least 2");
	end

	// =====================================================
	// axi write path: address and data held independently
	logic        aw_full_reg, w_full_reg, bvalid_reg;
	logic [4:0]  aw_addr_reg;
	logic        aw_high_reg;
	logic [31:0] w_data_reg;
	logic [3:0]  w_strb_reg;
	logic [1:0]  bresp_reg;
	wire         wr_go = aw_full_reg & w_full_reg & ~bvalid_reg;
	wire         wr_prop = wr_go & ~aw_high_reg & (aw_addr_reg == SCCE_OFS_PROP);
	wire         wr_val1 = wr_go & ~aw_high_reg & (aw_addr_reg == SCCE_OFS_VAL1);
	wire         wr_val2 = wr_go & ~aw_high_reg & (aw_addr_reg == SCCE_OFS_VAL2);
	wire         wr_ctrl = wr_go & ~aw_high_reg & (aw_addr_reg == SCCE_OFS_CTRL);
	wire         wr_stat = wr_go & ~aw_high_reg & (aw_addr_reg == SCCE_OFS_STATUS);
	wire         wr_ok   = wr_prop | wr_val1 | wr_val2 | wr_ctrl | wr_stat;
	wire         restart_wr = wr_ctrl & w_strb_reg[0] & w_data_reg[SCCE_CTRL_RESTART];
	assign s_axi_awready = ~aw_full_reg;
	assign s_axi_wready  = ~w_full_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;

	// byte-lane merge for 16-bit registers
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] s);
		merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	// write channel holding registers and response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_reg <= 1'b0;
			w_full_reg  <= 1'b0;
			bvalid_reg  <= 1'b0;
			aw_addr_reg <= 5'h00;
			aw_high_reg <= 1'b0;
			w_data_reg  <= 32'h0000_0000;
			w_strb_reg  <= 4'h0;
			bresp_reg   <= SCCE_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && !aw_full_reg) begin
				aw_full_reg <= 1'b1;
				aw_addr_reg <= {s_axi_awaddr[4:2], 2'b00};
				aw_high_reg <= |s_axi_awaddr[31:5];
			end else if (wr_go) begin
				aw_full_reg <= 1'b0;
			end
			if (s_axi_wvalid && !w_full_reg) begin
				w_full_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end else if (wr_go) begin
				w_full_reg <= 1'b0;
			end
			if (wr_go) begin
				bvalid_reg <= 1'b1;
				bresp_reg  <= wr_ok ? SCCE_RESP_OKAY : SCCE_RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	// =====================================================
	// pending and active parameters; active copy loads on restart
	logic [15:0] pend_prop_reg, act_prop_reg;
	logic [15:0] pend_val_reg [2];
	logic [15:0] act_val_reg [2];
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pend_prop_reg  <= SCCE_PROP_RST;
			pend_val_reg[0] <= SCCE_VAL_RST;
			pend_val_reg[1] <= SCCE_VAL_RST;
			act_prop_reg   <= SCCE_PROP_RST;
			act_val_reg[0] <= SCCE_VAL_RST;
			act_val_reg[1] <= SCCE_VAL_RST;
		end else begin
			if (wr_prop) pend_prop_reg <= merge16(pend_prop_reg, w_data_reg, w_strb_reg);
			if (wr_val1) pend_val_reg[0] <= merge16(pend_val_reg[0], w_data_reg, w_strb_reg);
			if (wr_val2) pend_val_reg[1] <= merge16(pend_val_reg[1], w_data_reg, w_strb_reg);
			if (restart_wr) begin
				act_prop_reg   <= pend_prop_reg;
				act_val_reg[0] <= pend_val_reg[0];
				act_val_reg[1] <= pend_val_reg[1];
			end
		end
	end
	wire [3:0] logic_sel = act_prop_reg[SCCE_LOGIC_LSB +: 4];
	assign transient_mode = act_prop_reg[SCCE_MODE_LSB +: 4];

	// =====================================================
	// step input: three flops, change accepted when second and third agree
	logic s1_reg, s2_reg, s3_reg, step_level_reg, step_prev_reg;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_reg         <= 1'b1;
			s2_reg         <= 1'b1;
			s3_reg         <= 1'b1;
			step_level_reg <= 1'b0;
			step_prev_reg  <= 1'b0;
		end else begin
			s1_reg <= position_step_input_n;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg) step_level_reg <= ~s3_reg; // input is active low
			step_prev_reg <= step_level_reg;
		end
	end
	wire step_rise = step_level_reg & ~step_prev_reg;
	wire step_fall = ~step_level_reg & step_prev_reg;

	// =====================================================
	// arming, millisecond timebase, handover
	logic        armed_reg, done_reg, handover_reg;
	logic [31:0] pre_reg;
	logic [16:0] ms_reg;
	logic [1:0]  cond_now;
	logic [1:0]  edge_seen_reg;
	wire         arm_pulse = restart_wr | group_start;
	wire         combined = (logic_sel == SCCE_LOGIC_AND) ? (cond_now[0] & cond_now[1]) :
		(logic_sel == SCCE_LOGIC_OR) ? (cond_now[0] | cond_now[1]) : cond_now[0];
	wire         fire = armed_reg & combined;
	wire         pre_wrap = (pre_reg == CLK_PER_MS - 1);

	// per-condition evaluation
	for (genvar i = 0; i < 2; i++) begin : g_cond
		wire [3:0]  ctype = act_prop_reg[4*i +: 4];
		wire [15:0] cval  = act_val_reg[i];
		wire edge_hit = ((cval == SCCE_EDGE_RISE) & step_rise) |
			((cval == SCCE_EDGE_FALL) & step_fall) |
			((cval == SCCE_EDGE_ANY) & (step_rise | step_fall));
		wire lvl_hit = ((cval == SCCE_LEVEL_HIGH) & step_level_reg) |
			((cval == SCCE_LEVEL_LOW) & ~step_level_reg);
		assign cond_now[i] = (ctype == SCCE_TYPE_UNCOND) ? 1'b1 :
			(ctype == SCCE_TYPE_DELAY) ? (ms_reg >= {1'b0, cval}) :
			(ctype == SCCE_TYPE_EDGE) ? edge_seen_reg[i] :
			(ctype == SCCE_TYPE_LEVEL) ? lvl_hit : 1'b0;
		// an edge is latched once per arming
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				edge_seen_reg[i] <= 1'b0;
			end else if (armed_reg && ctype == SCCE_TYPE_EDGE && edge_hit) begin
				edge_seen_reg[i] <= 1'b1; // an edge on the arm cycle is kept only if already armed
			end else if (arm_pulse) begin
				edge_seen_reg[i] <= 1'b0;
			end
		end
	end

	// evaluator state and timebase
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			armed_reg    <= 1'b0;
			done_reg     <= 1'b0;
			handover_reg <= 1'b0;
			pre_reg      <= 32'h0000_0000;
			ms_reg       <= 17'h00000;
		end else begin
			armed_reg    <= arm_pulse | (armed_reg & ~combined);
			done_reg     <= fire | (done_reg & ~arm_pulse);
			handover_reg <= fire & ~arm_pulse;
			if (arm_pulse || pre_wrap) pre_reg <= 32'h0000_0000;
			else pre_reg <= pre_reg + 32'h0000_0001;
			if (arm_pulse) ms_reg <= 17'h00000;
			else if (pre_wrap && !ms_reg[16]) ms_reg <= ms_reg + 17'h00001;
		end
	end
	assign handover_pulse = handover_reg;
	assign armed = armed_reg;

	// =====================================================
	// axi read path
	logic        rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0]  rresp_reg;
	wire  [4:0]  ra = {s_axi_araddr[4:2], 2'b00};
	wire         ra_ok = ~|s_axi_araddr[31:5];
	wire  [31:0] status_word = {24'h000000, transient_mode, cond_now, done_reg, armed_reg};
	wire  [31:0] rd_word = (!ra_ok) ? 32'h0000_0000 :
		(ra == SCCE_OFS_PROP) ? {16'h0000, pend_prop_reg} :
		(ra == SCCE_OFS_VAL1) ? {16'h0000, pend_val_reg[0]} :
		(ra == SCCE_OFS_VAL2) ? {16'h0000, pend_val_reg[1]} :
		(ra == SCCE_OFS_STATUS) ? status_word : 32'h0000_0000;
	wire         rd_ok = ra_ok & ((ra == SCCE_OFS_PROP) | (ra == SCCE_OFS_VAL1) |
		(ra == SCCE_OFS_VAL2) | (ra == SCCE_OFS_CTRL) | (ra == SCCE_OFS_STATUS));
	assign s_axi_arready = ~rvalid_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= 32'h0000_0000;
			rresp_reg  <= SCCE_RESP_OKAY;
		end else if (s_axi_arvalid && !rvalid_reg) begin
			rvalid_reg <= 1'b1;
			rdata_reg  <= rd_word;
			rresp_reg  <= rd_ok ? SCCE_RESP_OKAY : SCCE_RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	// =====================================================
	// assertions
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	handover_needs_arm_a: assert property (handover_reg |-> $past(armed_reg))
		else $error("handover without arming");
	uncond_fires_a: assert property (armed_reg && !arm_pulse && logic_sel == SCCE_LOGIC_NONE
		&& act_prop_reg[3:0] == SCCE_TYPE_UNCOND |=> handover_reg)
		else $error("unconditional did not fire");
	delay_reached_a: assert property (armed_reg && !arm_pulse && logic_sel == SCCE_LOGIC_NONE
		&& act_prop_reg[3:0] == SCCE_TYPE_DELAY && ms_reg >= {1'b0, act_val_reg[0]} |=> handover_reg)
		else $error("delay elapsed without handover");
	delay_early_a: assert property (handover_reg && logic_sel == SCCE_LOGIC_NONE
		&& act_prop_reg[3:0] == SCCE_TYPE_DELAY |-> $past(ms_reg) >= {1'b0, act_val_reg[0]})
		else $error("delay fired early");
	edge_once_a: assert property ($rose(edge_seen_reg[0]) |-> $past(step_rise | step_fall))
		else $error("edge latched without an edge");
	level_high_a: assert property (armed_reg && !arm_pulse && logic_sel == SCCE_LOGIC_NONE
		&& act_prop_reg[3:0] == SCCE_TYPE_LEVEL && act_val_reg[0] == SCCE_LEVEL_HIGH
		&& step_level_reg |=> handover_reg)
		else $error("high level did not fire");
	and_both_a: assert property (handover_reg && logic_sel == SCCE_LOGIC_AND
		|-> $past(cond_now[0] && cond_now[1]))
		else $error("and fired with one condition");
	restart_only_a: assert property ($changed(act_prop_reg) || $changed(act_val_reg[0])
		|| $changed(act_val_reg[1]) |-> $past(restart_wr))
		else $error("parameter took effect without restart");
	mode_follows_a: assert property ($changed(transient_mode) |-> $past(restart_wr))
		else $error("transient mode changed without restart");
	sync_agree_a: assert property ($changed(step_level_reg) |-> $past(s2_reg == s3_reg))
		else $error("step level changed before agreement");

endmodule // scce_top

// File: verif/scce_step_ctl.sv
// external controller model driving the active low step pin
module scce_step_ctl (
	// clock and command from the bench
	input  wire logic aclk,
	input  wire logic step_level,
	// step pin, low while the step input is asserted
	output      logic position_step_input_n
);
	timeunit 1ns;
	timeprecision 1ps;
	// =========================================
	// pin driver
	// pin idles high, the deasserted level
	initial position_step_input_n = 1'b1;
	// level changes 1 ns after each rising edge of aclk, the same clock the sampler inside uses
	always @(posedge aclk) begin
		position_step_input_n <= #1 ~step_level;
	end
endmodule // scce_step_ctl

// File: verif/tb_top.sv
// self-checking testbench for the step change condition evaluator
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import scce_pkg::*;
	localparam int PMS = 4;
	// =========================================
	// stimulus and observed signals
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic [31:0] s_axi_rdata, rd;
	logic position_step_input_n, group_start = 1'b0, step_level = 1'b0;
	logic handover_pulse, armed;
	logic [3:0] transient_mode;
	int n_fail = 0, total_checks = 0, n_pulse = 0, cyc = 0;
	// =========================================
	// clock, pulse tally and hang guard
	always #2.5 aclk = ~aclk;
	always @(posedge aclk) begin
		n_pulse <= n_pulse + (handover_pulse === 1'b1);
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			n_fail++;
			complete_run();
		end
	end
	scce_top #(.CLK_PER_MS(PMS)) u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.position_step_input_n, .group_start, .handover_pulse, .transient_mode, .armed);
	scce_step_ctl u_ctl (.aclk, .step_level, .position_step_input_n);
	// =========================================
	// shared tasks
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			n_fail++;
			$display("mismatch at %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// write with address and data offered together
	task automatic wr(input logic [4:0] o, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= {27'h0, o};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				s_axi_bready <= 1'b0;
				rsp = s_axi_bresp;
			end
		end while (s_axi_awvalid || s_axi_wvalid || s_axi_bready);
	endtask
	task automatic rdr(input logic [4:0] o);
		@(posedge aclk);
		s_axi_araddr <= {27'h0, o};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				s_axi_rready <= 1'b0;
				rd = s_axi_rdata;
				rsp = s_axi_rresp;
			end
		end while (s_axi_arvalid || s_axi_rready);
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge aclk);
		#1;
	endtask
	task automatic rearm();
		@(posedge aclk);
		group_start <= 1'b1;
		@(posedge aclk);
		group_start <= 1'b0;
	endtask
	// load parameters, restart, then move the step input once
	task automatic run(input logic [15:0] p, v1, v2, input logic l0, l1, input int e0, e1, e2);
		int b;
		step_level <= l0;
		idle(8);
		b = n_pulse;
		wr(SCCE_OFS_PROP, {16'h0, p});
		wr(SCCE_OFS_VAL1, {16'h0, v1});
		wr(SCCE_OFS_VAL2, {16'h0, v2});
		wr(SCCE_OFS_CTRL, 32'h1);
		idle(12);
		chk(n_pulse - b, e0);
		chk(transient_mode, p[15:12]);
		step_level <= l1;
		idle(12);
		chk(n_pulse - b, e1);
		rearm();
		idle(12);
		chk(n_pulse - b, e2);
		$display("test run %h done at %0t", p, $time);
	endtask
	task automatic t_regs();
		rdr(SCCE_OFS_PROP);
		chk(rd, 32'h0);
		rdr(SCCE_OFS_VAL2);
		chk(rd, 32'h0);
		wr(SCCE_OFS_VAL1, 32'h0001_ffff);
		rdr(SCCE_OFS_VAL1);
		chk(rd, 32'h0000_ffff);
		chk(rsp, SCCE_RESP_OKAY);
		rdr(5'h14);
		chk(rd, 32'h0000_0000);
		chk(rsp, SCCE_RESP_SLVERR);
		wr(5'h18, 32'h1);
		chk(rsp, SCCE_RESP_SLVERR);
		$display("test regs done at %0t", $time);
	endtask
	// delay counts milliseconds; new value waits for restart
	task automatic t_delay();
		int b;
		b = n_pulse;
		wr(SCCE_OFS_PROP, 32'h1);
		wr(SCCE_OFS_VAL1, 32'h5);
		wr(SCCE_OFS_CTRL, 32'h1);
		idle(14);
		chk(n_pulse - b, 0);
		chk(armed, 1'b1);
		idle(14);
		chk(n_pulse - b, 1);
		chk(armed, 1'b0);
		wr(SCCE_OFS_VAL1, 32'h0);
		rearm();
		idle(12);
		chk(n_pulse - b, 1);
		idle(16);
		chk(n_pulse - b, 2);
		wr(SCCE_OFS_CTRL, 32'h1);
		idle(4);
		chk(n_pulse - b, 3);
		// status: idle, done, both conditions met, mode 0
		rdr(SCCE_OFS_STATUS);
		chk(rd, 32'h0000_000e);
		chk(rsp, SCCE_RESP_OKAY);
		$display("test delay done at %0t", $time);
	endtask
	// =========================================
	// main sequence
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		run(16'h1000, 16'hffff, 0, 0, 0, 1, 1, 2);
		run(16'h2001, 0, 0, 0, 0, 1, 1, 2);
		run(16'h3002, 0, 0, 0, 1, 0, 1, 1);
		run(16'h4002, 1, 0, 0, 1, 0, 0, 0);
		run(16'h5002, 1, 0, 1, 0, 0, 1, 1);
		run(16'h0002, 2, 0, 1, 0, 0, 1, 1);
		run(16'h0002, 3, 0, 0, 1, 0, 0, 0);
		run(16'h0003, 3, 0, 0, 1, 0, 1, 2);
		run(16'h0003, 4, 0, 1, 0, 0, 1, 2);
		run(16'h0130, 0, 3, 0, 1, 0, 1, 2);
		run(16'h0231, 16'hffff, 3, 0, 1, 0, 1, 2);
		run(16'h0030, 0, 3, 0, 0, 1, 1, 2);
		t_delay();
		complete_run();
	end
endmodule // tb_top
